//--- sad_pkg.sv
package sad_pkg;

  localparam int ADDR_W = 32;
  localparam logic [5:0] BLK_CS0 = 6'h00;
  localparam logic [5:0] BLK_CS5 = 6'h05;
  localparam logic [5:0] BLK_PCC0 = 6'h08;
  localparam logic [5:0] BLK_PCC1 = 6'h0C;
  localparam logic [5:0] BLK_PERIPH = 6'h10;
  localparam logic [5:0] BLK_LCD = 6'h11;
  localparam logic [5:0] BLK_MEMC = 6'h12;
  localparam logic [5:0] BLK_USBH = 6'h13;
  localparam logic [5:0] BLK_CAPT = 6'h14;
  localparam logic [5:0] BLK_RSV_15 = 6'h15;
  localparam logic [5:0] BLK_IMEM_CTL = 6'h16;
  localparam logic [5:0] BLK_IMEM = 6'h17;
  localparam logic [5:0] BLK_SDR0 = 6'h28;
  localparam logic [5:0] BLK_SDR3 = 6'h2B;
  localparam logic [3:0] NIB_SDR2_L = 4'h8;
  localparam logic [3:0] NIB_SDR3_L = 4'h9;
  localparam logic [3:0] NIB_SDR0_L = 4'hA;
  localparam logic [3:0] NIB_SDR1_L = 4'hB;
  localparam int IMEM_BYTES = 262144;
  localparam int IMEM_AW = 18;

  localparam int NUM_TGT = 16;
  typedef enum logic [3:0] {
    SAD_T_CS0 = 4'h0, SAD_T_CS1 = 4'h1, SAD_T_CS2 = 4'h2, SAD_T_CS3 = 4'h3,
    SAD_T_CS4 = 4'h4, SAD_T_CS5 = 4'h5, SAD_T_PCC0 = 4'h6, SAD_T_PCC1 = 4'h7,
    SAD_T_PERIPH = 4'h8, SAD_T_LCD = 4'h9, SAD_T_MEMC = 4'hA, SAD_T_USBH = 4'hB,
    SAD_T_CAPT = 4'hC, SAD_T_IMEM_CTL = 4'hD, SAD_T_IMEM = 4'hE, SAD_T_SDRAM = 4'hF
  } sad_tgt_e;

  typedef enum logic [1:0] {
    SAD_PC_IO = 2'h0, SAD_PC_RSV = 2'h1, SAD_PC_ATTR = 2'h2, SAD_PC_MEM = 2'h3
  } sad_pcspace_e;

  localparam logic [3:0] CP_INTC = 4'h6;
  localparam logic [3:0] CP_DBG = 4'hE;
  localparam logic [3:0] CP_SYS = 4'hF;
  localparam int CP_SEL_W = 6;

  typedef enum logic [1:0] {
    SAD_ST_IDLE = 2'b00, SAD_ST_LOAD = 2'b01, SAD_ST_RUN = 2'b11
  } sad_state_e;
  localparam logic [1:0] RST_SDR_PART = 2'h0;

endpackage : sad_pkg

//--- sad_mem_dec.sv
`timescale 1ns/1ps
module sad_mem_dec (
  input wire logic [31:0] addr,
  input wire logic static_wide,
  input wire logic sdram_large,
  output logic hit,
  output logic [3:0] tgt,
  output logic [1:0] sdr_part,
  output logic [1:0] pc_space
);
  logic [5:0] blk;
  logic [3:0] nib;
  always_comb begin
    blk = addr[31:26];
    nib = addr[31:28];
    hit = 1'b1;
    tgt = sad_pkg::SAD_T_CS0;
    sdr_part = sad_pkg::RST_SDR_PART;
    // Card space only means something for socket hits
    pc_space = 2'h0;
    if (blk <= sad_pkg::BLK_CS5) begin
      if (static_wide && blk < 6'h04) begin
        tgt = {3'h0, blk[1]};
      end else begin
        tgt = blk[3:0];
      end
    end else if (nib == 4'h2) begin
      tgt = sad_pkg::SAD_T_PCC0;
      pc_space = addr[27:26];
    end else if (nib == 4'h3) begin
      tgt = sad_pkg::SAD_T_PCC1;
      pc_space = addr[27:26];
    end else if (blk >= sad_pkg::BLK_PERIPH && blk <= sad_pkg::BLK_IMEM && blk != sad_pkg::BLK_RSV_15) begin
      tgt = blk[3:0] + 4'h8;
      if (blk == sad_pkg::BLK_IMEM_CTL) tgt = sad_pkg::SAD_T_IMEM_CTL;
      if (blk == sad_pkg::BLK_IMEM) tgt = sad_pkg::SAD_T_IMEM;
      if (blk == sad_pkg::BLK_IMEM && addr[25:sad_pkg::IMEM_AW] != '0) hit = 1'b0;
    end else if (!sdram_large && blk >= sad_pkg::BLK_SDR0 && blk <= sad_pkg::BLK_SDR3) begin
      tgt = sad_pkg::SAD_T_SDRAM;
      sdr_part = blk[1:0];
    end else if (sdram_large && nib >= sad_pkg::NIB_SDR2_L && nib <= sad_pkg::NIB_SDR1_L) begin
      tgt = sad_pkg::SAD_T_SDRAM;
      sdr_part = {~nib[1], nib[0]};
    end else begin
      hit = 1'b0;
    end
  end
endmodule : sad_mem_dec

//--- sad_cp_dec.sv
`timescale 1ns/1ps
module sad_cp_dec (
  input wire logic [3:0] cp_num,
  input wire logic [3:0] primary_coproc_regnum,
  input wire logic [3:0] secondary_coproc_regnum,
  input wire logic [2:0] op2,
  output logic hit,
  output logic [5:0] sel
);
  // sel: {cp group[1:0], index[3:0]}; group 1=cp6, 2=cp14, 3=cp15
  always_comb begin
    hit = 1'b0;
    sel = '0;
    unique case (cp_num)
      sad_pkg::CP_INTC: begin
        if (primary_coproc_regnum <= 4'h5 && secondary_coproc_regnum == 4'h0 && op2 == 3'h0) begin
          hit = 1'b1;
          sel = {2'h1, primary_coproc_regnum};
        end
      end
      sad_pkg::CP_DBG: begin
        if (primary_coproc_regnum != 4'h4 && primary_coproc_regnum != 4'h5 && primary_coproc_regnum != 4'hF && secondary_coproc_regnum == 4'h0 && op2 == 3'h0) begin
          hit = 1'b1;
          sel = {2'h2, primary_coproc_regnum};
        end
      end
      sad_pkg::CP_SYS: begin
        unique case (primary_coproc_regnum)
          4'h7: begin
            hit = (secondary_coproc_regnum == 4'h7 && op2 == 3'h0) || (secondary_coproc_regnum == 4'h5 && (op2 == 3'h0 || op2 == 3'h1 || op2 == 3'h6))
              || (secondary_coproc_regnum == 4'h6 && op2 <= 3'h1) || (secondary_coproc_regnum == 4'hA && (op2 == 3'h1 || op2 == 3'h4))
              || (secondary_coproc_regnum == 4'h2 && op2 == 3'h5);
            sel = {2'h3, 4'h7};
          end
          4'h8: begin
            hit = (secondary_coproc_regnum == 4'h7 && op2 == 3'h0) || ((secondary_coproc_regnum == 4'h5 || secondary_coproc_regnum == 4'h6) && op2 <= 3'h1);
            sel = {2'h3, 4'h8};
          end
          4'hA: begin
            hit = (secondary_coproc_regnum == 4'h4 || secondary_coproc_regnum == 4'h8) && op2 <= 3'h1;
            sel = {2'h3, 4'hA};
          end
          4'hE: begin
            hit = (secondary_coproc_regnum == 4'h0 || secondary_coproc_regnum == 4'h3 || secondary_coproc_regnum == 4'h4 || secondary_coproc_regnum == 4'h8 || secondary_coproc_regnum == 4'h9) && op2 == 3'h0;
            sel = {2'h3, 4'hE};
          end
          default: begin
            hit = 1'b0;
            sel = '0;
          end
        endcase
      end
      default: begin
        hit = 1'b0;
        sel = '0;
      end
    endcase
  end
endmodule : sad_cp_dec

//--- sad_top.sv
`timescale 1ns/1ps
// What this block does
// - Reserved top-level region access raises data abort
// - Reserved peripheral offsets complete without abort
// - Bits 31:26 pick one of 64 blocks
// - Unit field; bits 25:24 zero on device
// - Sub-unit bits 19:11 treated as zero
// - Default map: six 64 Mbyte chip selects
// - Wide option: CS0/CS1 get 128 Mbyte each
// - Two 256 Mbyte PC Card sockets, three spaces
// - Route peripheral, LCD, memctl, USB, capture windows
// - 0x54 reserved; internal memory control and array
// - Bus units below 0x6000_0000; above reserved except SDRAM
// - Default SDRAM: four 64 Mbyte partitions
// - Large map: four 256 Mbyte partitions
// - Cp6 decodes interrupt controller registers 0-5
// - Cp14 performance, clock, power registers
// - Cp14 debug, trace, checkpoint registers
// - Cp15 register 7 cache operations
// - Cp15 register 8 TLB invalidation
// - Cp15 register 10 TLB lock and unlock
// - Cp15 register 14 breakpoint registers
module sad_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic static_wide_req,
  input wire logic sdram_large_req,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic cp_req,
  input wire logic [3:0] cp_num,
  input wire logic [3:0] cp_crn,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_op2,
  output logic mem_valid,
  output logic [15:0] tgt_sel,
  output logic [31:0] tgt_addr,
  output logic [1:0] sdram_part,
  output logic [1:0] pc_space,
  output logic data_abort,
  output logic cp_valid,
  output logic [5:0] cp_sel,
  output logic cp_undef,
  output logic static_wide,
  output logic sdram_large
);
  sad_pkg::sad_state_e state_ff, nxt_state;
  logic static_wide_ff, nxt_static_wide;
  logic sdram_large_ff, nxt_sdram_large;
  logic dec_hit, cpd_hit;
  logic [3:0] dec_tgt;
  logic [1:0] dec_part, dec_pc;
  logic [5:0] cpd_sel;
  logic mem_valid_ff, nxt_mem_valid;
  logic [15:0] tgt_sel_ff, nxt_tgt_sel;
  logic [31:0] tgt_addr_ff, nxt_tgt_addr;
  logic [1:0] part_ff, nxt_part, pc_ff, nxt_pc;
  logic abort_ff, nxt_abort;
  logic cp_valid_ff, nxt_cp_valid;
  logic [5:0] cp_sel_ff, nxt_cp_sel;
  logic cp_undef_ff, nxt_cp_undef;

  sad_mem_dec u_mem_dec (
    .addr(mem_addr),
    .static_wide(static_wide_ff),
    .sdram_large(sdram_large_ff),
    .hit(dec_hit),
    .tgt(dec_tgt),
    .sdr_part(dec_part),
    .pc_space(dec_pc)
  );

  sad_cp_dec u_cp_dec (
    .cp_num(cp_num),
    .primary_coproc_regnum(cp_crn),
    .secondary_coproc_regnum(cp_crm),
    .op2(cp_op2),
    .hit(cpd_hit),
    .sel(cpd_sel)
  );

  // Options sampled after reset and again in RUN only while no request is pending or reported, so decode never shifts under traffic
  always_comb begin
    nxt_state = state_ff;
    nxt_static_wide = static_wide_ff;
    nxt_sdram_large = sdram_large_ff;
    unique case (state_ff)
      sad_pkg::SAD_ST_IDLE: nxt_state = sad_pkg::SAD_ST_LOAD;
      sad_pkg::SAD_ST_LOAD: begin
        nxt_static_wide = static_wide_req;
        nxt_sdram_large = sdram_large_req;
        nxt_state = sad_pkg::SAD_ST_RUN;
      end
      sad_pkg::SAD_ST_RUN: begin
        if (!mem_req && !mem_valid_ff) begin
          nxt_static_wide = static_wide_req;
          nxt_sdram_large = sdram_large_req;
        end
      end
      default: nxt_state = sad_pkg::SAD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff <= sad_pkg::SAD_ST_IDLE;
      static_wide_ff <= 1'b0;
      sdram_large_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      static_wide_ff <= nxt_static_wide;
      sdram_large_ff <= nxt_sdram_large;
    end
  end

  // Requests before options settle are held off by reporting nothing
  always_comb begin
    logic go;
    go = mem_req && state_ff == sad_pkg::SAD_ST_RUN;
    nxt_mem_valid = go;
    nxt_tgt_sel = '0;
    nxt_abort = 1'b0;
    nxt_part = '0;
    nxt_pc = '0;
    nxt_tgt_addr = tgt_addr_ff;
    if (go) begin
      // Bits 19:11 ignored inside units; peripheral holes return junk, no abort
      nxt_tgt_addr = {mem_addr[31:20], 9'h000, mem_addr[10:0]};
      if (dec_hit) begin
        nxt_tgt_sel[dec_tgt] = 1'b1;
        nxt_part = dec_part;
        nxt_pc = dec_pc;
      end else begin
        nxt_abort = 1'b1;
      end
    end
    nxt_cp_valid = cp_req && state_ff == sad_pkg::SAD_ST_RUN;
    nxt_cp_sel = (nxt_cp_valid && cpd_hit) ? cpd_sel : 6'h00;
    nxt_cp_undef = nxt_cp_valid && !cpd_hit;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mem_valid_ff <= 1'b0;
      tgt_sel_ff <= '0;
      tgt_addr_ff <= '0;
      part_ff <= '0;
      pc_ff <= '0;
      abort_ff <= 1'b0;
      cp_valid_ff <= 1'b0;
      cp_sel_ff <= '0;
      cp_undef_ff <= 1'b0;
    end else if (clk_en) begin
      mem_valid_ff <= nxt_mem_valid;
      tgt_sel_ff <= nxt_tgt_sel;
      tgt_addr_ff <= nxt_tgt_addr;
      part_ff <= nxt_part;
      pc_ff <= nxt_pc;
      abort_ff <= nxt_abort;
      cp_valid_ff <= nxt_cp_valid;
      cp_sel_ff <= nxt_cp_sel;
      cp_undef_ff <= nxt_cp_undef;
    end
  end

  assign mem_valid = mem_valid_ff;
  assign tgt_sel = tgt_sel_ff;
  assign tgt_addr = tgt_addr_ff;
  assign sdram_part = part_ff;
  assign pc_space = pc_ff;
  assign data_abort = abort_ff;
  assign cp_valid = cp_valid_ff;
  assign cp_sel = cp_sel_ff;
  assign cp_undef = cp_undef_ff;
  assign static_wide = static_wide_ff;
  assign sdram_large = sdram_large_ff;

  property p_onehot;
    @(posedge clk_sys) disable iff (!rst_n)
      mem_valid |-> $onehot({tgt_sel, data_abort});
  endproperty
  a_onehot: assert property (p_onehot) else $error("select not one-hot");

  property p_resv_abort;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && mem_req && state_ff == sad_pkg::SAD_ST_RUN && mem_addr[31:26] == 6'h15 |=> data_abort;
  endproperty
  a_resv_abort: assert property (p_resv_abort) else $error("reserved 0x54 no abort");

  property p_high_abort;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && mem_req && state_ff == sad_pkg::SAD_ST_RUN && mem_addr[31:30] == 2'b11 |=> data_abort;
  endproperty
  a_high_abort: assert property (p_high_abort) else $error("high space no abort");

  property p_cs4;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && mem_req && state_ff == sad_pkg::SAD_ST_RUN && mem_addr[31:26] == 6'h04 |=> tgt_sel[4];
  endproperty
  a_cs4: assert property (p_cs4) else $error("cs4 not selected");

  property p_wide;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && mem_req && state_ff == sad_pkg::SAD_ST_RUN && static_wide_ff && mem_addr[31:26] == 6'h03
      |=> tgt_sel[1] && !tgt_sel[3];
  endproperty
  a_wide: assert property (p_wide) else $error("wide cs1 wrong");

  property p_capt;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && mem_req && state_ff == sad_pkg::SAD_ST_RUN && mem_addr[31:26] == 6'h14 |=> tgt_sel[12];
  endproperty
  a_capt: assert property (p_capt) else $error("capture not routed");

  property p_sdr_def;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && mem_req && state_ff == sad_pkg::SAD_ST_RUN && !sdram_large_ff && mem_addr[31:26] == 6'h2B
      |=> tgt_sel[15] && sdram_part == 2'h3;
  endproperty
  a_sdr_def: assert property (p_sdr_def) else $error("sdram part 3 wrong");

  property p_sdr_big;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && mem_req && state_ff == sad_pkg::SAD_ST_RUN && sdram_large_ff && mem_addr[31:28] == 4'h8
      |=> tgt_sel[15] && sdram_part == 2'h2;
  endproperty
  a_sdr_big: assert property (p_sdr_big) else $error("large sdram part 2 wrong");

  property p_opt_stable;
    @(posedge clk_sys) disable iff (!rst_n)
      mem_valid && state_ff == sad_pkg::SAD_ST_RUN |-> $stable(static_wide_ff) && $stable(sdram_large_ff);
  endproperty
  a_opt_stable: assert property (p_opt_stable) else $error("option moved in flight");

  property p_cp6;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && cp_req && state_ff == sad_pkg::SAD_ST_RUN && cp_num == 4'h6 && cp_crn == 4'h3
      && cp_crm == 4'h0 && cp_op2 == 3'h0 |=> cp_sel == 6'h13 && !cp_undef;
  endproperty
  a_cp6: assert property (p_cp6) else $error("cp6 fiq pending not decoded");

  property p_cp14_rsv;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && cp_req && state_ff == sad_pkg::SAD_ST_RUN && cp_num == 4'hE && cp_crn == 4'hF |=> cp_undef;
  endproperty
  a_cp14_rsv: assert property (p_cp14_rsv) else $error("cp14 15 not refused");

  property p_pcc1;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && mem_req && state_ff == sad_pkg::SAD_ST_RUN && mem_addr[31:28] == 4'h3
      |=> tgt_sel[7] && pc_space == $past(mem_addr[27:26]);
  endproperty
  a_pcc1: assert property (p_pcc1) else $error("socket 1 space wrong");

  property p_periph_hole;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && mem_req && state_ff == sad_pkg::SAD_ST_RUN && mem_addr[31:28] == 4'h4
      |=> mem_valid && !data_abort;
  endproperty
  a_periph_hole: assert property (p_periph_hole) else $error("peripheral space aborted");

  property p_imem_ctl;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && mem_req && state_ff == sad_pkg::SAD_ST_RUN && mem_addr[31:26] == 6'h16
      |=> tgt_sel[13];
  endproperty
  a_imem_ctl: assert property (p_imem_ctl) else $error("memory control not routed");

  property p_imem_over;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && mem_req && state_ff == sad_pkg::SAD_ST_RUN && mem_addr[31:26] == 6'h17
      && mem_addr[25:18] != 8'h00 |=> data_abort;
  endproperty
  a_imem_over: assert property (p_imem_over) else $error("array overrun no abort");

  property p_sub_unit;
    @(posedge clk_sys) disable iff (!rst_n)
      mem_valid |-> tgt_addr[19:11] == 9'h000;
  endproperty
  a_sub_unit: assert property (p_sub_unit) else $error("sub-unit bits not cleared");

  property p_cp14_clk;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && cp_req && state_ff == sad_pkg::SAD_ST_RUN && cp_num == 4'hE && cp_crn == 4'h6
      && cp_crm == 4'h0 && cp_op2 == 3'h0 |=> cp_sel == 6'h26 && !cp_undef;
  endproperty
  a_cp14_clk: assert property (p_cp14_clk) else $error("cp14 clock config not decoded");

  property p_cp15_cache;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && cp_req && state_ff == sad_pkg::SAD_ST_RUN && cp_num == 4'hF && cp_crn == 4'h7
      && cp_crm == 4'hA && cp_op2 == 3'h4 |=> cp_sel == 6'h37 && !cp_undef;
  endproperty
  a_cp15_cache: assert property (p_cp15_cache) else $error("drain buffer not decoded");

  property p_cp15_tlb;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && cp_req && state_ff == sad_pkg::SAD_ST_RUN && cp_num == 4'hF && cp_crn == 4'h8
      && cp_crm == 4'h6 && cp_op2 == 3'h1 |=> cp_sel == 6'h38 && !cp_undef;
  endproperty
  a_cp15_tlb: assert property (p_cp15_tlb) else $error("data tlb entry not decoded");

  property p_cp15_lock;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && cp_req && state_ff == sad_pkg::SAD_ST_RUN && cp_num == 4'hF && cp_crn == 4'hA
      && cp_crm == 4'h8 && cp_op2 == 3'h1 |=> cp_sel == 6'h3A && !cp_undef;
  endproperty
  a_cp15_lock: assert property (p_cp15_lock) else $error("data tlb unlock not decoded");

  property p_cp15_bkpt;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && cp_req && state_ff == sad_pkg::SAD_ST_RUN && cp_num == 4'hF && cp_crn == 4'hE
      && cp_crm == 4'h3 && cp_op2 == 3'h0 |=> cp_sel == 6'h3E && !cp_undef;
  endproperty
  a_cp15_bkpt: assert property (p_cp15_bkpt) else $error("data breakpoint b not decoded");

  property p_cp_excl;
    @(posedge clk_sys) disable iff (!rst_n)
      cp_valid |-> (cp_sel != 6'h00) != cp_undef;
  endproperty
  a_cp_excl: assert property (p_cp_excl) else $error("cp select and undef clash");

endmodule : sad_top

//--- sad_core_model.sv
`timescale 1ns/1ps
module sad_core_model (
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic cp_req,
  output logic [3:0] cp_num,
  output logic [3:0] cp_crn,
  output logic [3:0] cp_crm,
  output logic [2:0] cp_op2
);
  initial begin
    mem_req = 1'h0;
    mem_addr = 32'h0;
    cp_req = 1'h0;
    {cp_num, cp_crn, cp_crm, cp_op2} = 15'h0;
  end

  task automatic mem_start(input logic [31:0] a);
    mem_req = 1'h1;
    mem_addr = {a[31:2], 2'h0};
  endtask : mem_start

  // Released bus shows the inverse so a stale address is never reused
  task automatic mem_stop();
    mem_req = 1'h0;
    mem_addr = ~mem_addr;
  endtask : mem_stop

  task automatic cp_start(input logic [14:0] f);
    cp_req = 1'h1;
    {cp_num, cp_crn, cp_crm, cp_op2} = f;
  endtask : cp_start

  task automatic cp_stop();
    cp_req = 1'h0;
    {cp_num, cp_crn, cp_crm, cp_op2} = ~{cp_num, cp_crn, cp_crm, cp_op2};
  endtask : cp_stop
endmodule : sad_core_model

//--- system_address_decoder_tb.sv
`timescale 1ns/1ps
module system_address_decoder_tb;
  typedef struct {logic [31:0] a; logic [1:0] o; logic [4:0] t; logic [1:0] s;} sad_row_s;
  logic clk_sys;
  logic rst_n = 1'h0;
  logic clk_en = 1'h1;
  logic static_wide_req = 1'h0;
  logic sdram_large_req = 1'h0;
  logic mem_req, cp_req, mem_valid, data_abort, cp_valid, cp_undef, static_wide, sdram_large;
  logic [31:0] mem_addr, tgt_addr;
  logic [3:0] cp_num, cp_crn, cp_crm;
  logic [2:0] cp_op2;
  logic [15:0] tgt_sel;
  logic [1:0] sdram_part, pc_space;
  logic [5:0] cp_sel;
  int failures = 0;
  int compares = 0;
  // Target in t[3:0], t[4] marks abort; s is partition or card space
  sad_row_s rows [] = '{
    '{32'h0000_0000, 2'h0, 5'h00, 2'h0}, '{32'h0400_1234, 2'h0, 5'h01, 2'h0},
    '{32'h0800_0000, 2'h0, 5'h02, 2'h0}, '{32'h0C00_0000, 2'h0, 5'h03, 2'h0},
    '{32'h1000_0000, 2'h0, 5'h04, 2'h0}, '{32'h17FF_FFFC, 2'h0, 5'h05, 2'h0},
    '{32'h1800_0000, 2'h0, 5'h10, 2'h0}, '{32'h1C00_0000, 2'h0, 5'h10, 2'h0},
    '{32'h2000_0000, 2'h0, 5'h06, 2'h0}, '{32'h2400_0000, 2'h0, 5'h06, 2'h1},
    '{32'h2C00_0000, 2'h0, 5'h06, 2'h3}, '{32'h3800_0000, 2'h0, 5'h07, 2'h2},
    '{32'h4000_0000, 2'h0, 5'h08, 2'h0}, '{32'h4400_0270, 2'h0, 5'h09, 2'h0},
    '{32'h4800_0000, 2'h0, 5'h0A, 2'h0}, '{32'h4C00_0000, 2'h0, 5'h0B, 2'h0},
    '{32'h5000_003C, 2'h0, 5'h0C, 2'h0}, '{32'h5400_0000, 2'h0, 5'h10, 2'h0},
    '{32'h5800_0000, 2'h0, 5'h0D, 2'h0}, '{32'h5C03_FFFC, 2'h0, 5'h0E, 2'h0},
    '{32'h5C04_0000, 2'h0, 5'h10, 2'h0}, '{32'h6000_0000, 2'h0, 5'h10, 2'h0},
    '{32'h7C00_0000, 2'h0, 5'h10, 2'h0}, '{32'h8000_0000, 2'h0, 5'h10, 2'h0},
    '{32'hA000_0000, 2'h0, 5'h0F, 2'h0}, '{32'hA400_0000, 2'h0, 5'h0F, 2'h1},
    '{32'hA800_0000, 2'h0, 5'h0F, 2'h2}, '{32'hAC00_1000, 2'h0, 5'h0F, 2'h3},
    '{32'hB000_0000, 2'h0, 5'h10, 2'h0}, '{32'hFC00_0000, 2'h0, 5'h10, 2'h0},
    '{32'h0400_0000, 2'h2, 5'h00, 2'h0}, '{32'h0C00_0000, 2'h2, 5'h01, 2'h0},
    '{32'h1400_0000, 2'h2, 5'h05, 2'h0}, '{32'h1800_0000, 2'h2, 5'h10, 2'h0},
    '{32'h8000_0000, 2'h1, 5'h0F, 2'h2}, '{32'h9000_0000, 2'h1, 5'h0F, 2'h3},
    '{32'hA400_0000, 2'h1, 5'h0F, 2'h0}, '{32'hBFFF_FFFC, 2'h1, 5'h0F, 2'h1},
    '{32'hC000_0000, 2'h1, 5'h10, 2'h0}};
  // Packed as {crn, crm, op2, decoded}
  logic [11:0] cp15_rows [] = '{12'h771, 12'h751, 12'h753, 12'h761, 12'h763, 12'h75D, 12'h7A3,
    12'h7A9, 12'h72B, 12'h871, 12'h851, 12'h853, 12'h861, 12'h863, 12'hA41, 12'hA43, 12'hA81,
    12'hA83, 12'hE01, 12'hE31, 12'hE41, 12'hE81, 12'hE91, 12'h000, 12'hB00, 12'hD00,
    12'h772, 12'h8A0, 12'hA84, 12'hE02, 12'hE10};

  sad_top i_sad_top (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .static_wide_req(static_wide_req), .sdram_large_req(sdram_large_req), .mem_req(mem_req),
    .mem_addr(mem_addr), .cp_req(cp_req), .cp_num(cp_num), .cp_crn(cp_crn), .cp_crm(cp_crm),
    .cp_op2(cp_op2), .mem_valid(mem_valid), .tgt_sel(tgt_sel), .tgt_addr(tgt_addr),
    .sdram_part(sdram_part), .pc_space(pc_space), .data_abort(data_abort), .cp_valid(cp_valid),
    .cp_sel(cp_sel), .cp_undef(cp_undef), .static_wide(static_wide), .sdram_large(sdram_large));

  sad_core_model i_sad_core_model (.mem_req(mem_req), .mem_addr(mem_addr), .cp_req(cp_req),
    .cp_num(cp_num), .cp_crn(cp_crn), .cp_crm(cp_crm), .cp_op2(cp_op2));

  initial begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic mem_chk(input sad_row_s r);
    logic [15:0] sel;
    sel = r.t[4] ? 16'h0 : 16'h0001 << r.t[3:0];
    chk({31'h0, mem_valid}, 32'h1);
    chk({31'h0, data_abort}, {31'h0, r.t[4]});
    chk({16'h0, tgt_sel}, {16'h0, sel});
    chk({30'h0, sdram_part}, (r.t == 5'h0F) ? {30'h0, r.s} : 32'h0);
    chk({30'h0, pc_space}, (r.t == 5'h06 || r.t == 5'h07) ? {30'h0, r.s} : 32'h0);
    if (!r.t[4]) chk(tgt_addr, r.a & 32'hFFF0_07FF);
  endtask : mem_chk

  task automatic cp_go(input logic [14:0] f, input logic [5:0] sel, input logic ok);
    i_sad_core_model.cp_start(f);
    tick();
    i_sad_core_model.cp_stop();
    chk({31'h0, cp_valid}, 32'h1);
    chk({31'h0, cp_undef}, {31'h0, !ok});
    chk({26'h0, cp_sel}, ok ? {26'h0, sel} : 32'h0);
    tick();
  endtask : cp_go

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  initial begin
    #(25 * 3000);
    failures++;
    final_report();
  end

  initial begin
    repeat (10) tick();
    chk({tgt_sel, 10'h0, mem_valid, data_abort, cp_valid, cp_undef, static_wide, sdram_large}, 32'h0);
    chk(tgt_addr, 32'h0);
    rst_n = 1'h1;
    i_sad_core_model.mem_start(32'h4000_0000);
    i_sad_core_model.cp_start(15'h3000);
    repeat (2) begin
      tick();
      chk({30'h0, mem_valid, cp_valid}, 32'h0);
    end
    i_sad_core_model.mem_stop();
    i_sad_core_model.cp_stop();
    tick();
    chk({30'h0, mem_valid, cp_valid}, 32'h0);
    $display("test reset done");
    // Option change while requests stream must not retarget them
    i_sad_core_model.mem_start(32'h0400_0000);
    static_wide_req = 1'h1;
    tick();
    mem_chk('{32'h0400_0000, 2'h0, 5'h01, 2'h0});
    tick();
    i_sad_core_model.mem_stop();
    mem_chk('{32'h0400_0000, 2'h0, 5'h01, 2'h0});
    tick();
    chk({15'h0, mem_valid, tgt_sel}, 32'h0);
    repeat (2) tick();
    chk({31'h0, static_wide}, 32'h1);
    static_wide_req = 1'h0;
    repeat (3) tick();
    $display("test stream done");
    i_sad_core_model.mem_start(32'h5000_0000);
    clk_en = 1'h0;
    repeat (2) tick();
    chk({31'h0, mem_valid}, 32'h0);
    clk_en = 1'h1;
    tick();
    i_sad_core_model.mem_stop();
    mem_chk('{32'h5000_0000, 2'h0, 5'h0C, 2'h0});
    $display("test enable done");
    foreach (rows[i]) begin
      {static_wide_req, sdram_large_req} = rows[i].o;
      repeat (3) tick();
      chk({30'h0, static_wide, sdram_large}, {30'h0, rows[i].o});
      i_sad_core_model.mem_start(rows[i].a);
      tick();
      i_sad_core_model.mem_stop();
      mem_chk(rows[i]);
    end
    $display("test map done");
    for (int n = 0; n < 32; n++) begin
      cp_go({n[4] ? 4'hE : 4'h6, n[3:0], 7'h0}, {n[4] ? 2'h2 : 2'h1, n[3:0]},
        n[4] ? !(n[3:0] inside {4'h4, 4'h5, 4'hF}) : (n[3:0] < 4'h6));
    end
    cp_go(15'h3088, 6'h0, 1'h0);
    cp_go(15'h2800, 6'h0, 1'h0);
    foreach (cp15_rows[i]) begin
      cp_go({4'hF, cp15_rows[i][11:1]}, {2'h3, cp15_rows[i][11:8]}, cp15_rows[i][0]);
    end
    $display("test coprocessor done");
    i_sad_core_model.mem_start(32'h4800_0000);
    rst_n = 1'h0;
    tick();
    chk({15'h0, mem_valid, tgt_sel}, 32'h0);
    // Request held across release: dropped twice, then taken
    rst_n = 1'h1;
    repeat (2) begin
      tick();
      chk({31'h0, mem_valid}, 32'h0);
    end
    tick();
    i_sad_core_model.mem_stop();
    mem_chk('{32'h4800_0000, 2'h1, 5'h0A, 2'h0});
    $display("test midrun reset done");
    final_report();
  end
endmodule : system_address_decoder_tb
